// [verilog/mws_cfg.svh]
// Constants of the microstep wave sequencer: offsets, field positions, reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MWS_CFG_SVH
`define MWS_CFG_SVH

`define MWS_DATA_W        32
`define MWS_ADDR_W        8
`define MWS_TABLE_WORDS   8
`define MWS_POS_W         10
`define MWS_CUR_W         9
`define MWS_SYNC_DEPTH    3

`define MWS_OFS_TABLE0    8'h00
`define MWS_OFS_SEGSEL    8'h20
`define MWS_OFS_START     8'h24
`define MWS_OFS_CTRL0     8'h28
`define MWS_OFS_STAT0     8'h30

`define MWS_SEL_W_LSB     0
`define MWS_SEL_X1_LSB    8
`define MWS_SEL_X2_LSB    16
`define MWS_SEL_X3_LSB    24
`define MWS_START_A_LSB   0
`define MWS_START_B_LSB   16

`define MWS_CTRL_RES_LSB  0
`define MWS_CTRL_DEDGE    4
`define MWS_CTRL_EXT      5
`define MWS_CTRL_FS       6
`define MWS_CTRL_MASK     32'h0000007F
`define MWS_RES_MAX       4'h8

`define MWS_RST_TABLE0    32'hAAAAB554
`define MWS_RST_TABLE1    32'h4A9554AA
`define MWS_RST_TABLE2    32'h24492929
`define MWS_RST_TABLE3    32'h10104222
`define MWS_RST_TABLE4    32'hFBFFFFFF
`define MWS_RST_TABLE5    32'hB5BB777D
`define MWS_RST_TABLE6    32'h49295556
`define MWS_RST_TABLE7    32'h00404222
`define MWS_RST_SEGSEL    32'hFFFF8056
`define MWS_RST_START     32'h00F70000
`define MWS_RST_CTRL      32'h00000000

`endif

// [verilog/mws_pkg.sv]
// Types shared by the microstep wave sequencer, its port checker and its testbench.
// Assumes the constants header is on the include path.
`include "mws_cfg.svh"

package mws_pkg;

    typedef enum logic [1:0] {
        MWS_IDLE  = 2'b00,
        MWS_FETCH = 2'b01,
        MWS_APPLY = 2'b10
    } mws_seq_t;

    typedef struct packed {
        logic [`MWS_ADDR_W-1:0] addr;
        logic [`MWS_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } mws_bus_t;

    typedef struct packed {
        logic [`MWS_CUR_W-1:0] coil_b_current;
        logic [`MWS_CUR_W-1:0] coil_a_current;
    } mws_coil_t;

    typedef struct packed {
        logic [`MWS_SYNC_DEPTH-1:0] step_sy;
        logic [`MWS_SYNC_DEPTH-1:0] dir_sy;
        logic                       step_lv;
        logic                       dir_lv;
        mws_seq_t                   seq;
        logic [`MWS_POS_W-1:0]      pos;
        mws_coil_t                  coil;
        logic [8:0]                 left;
        logic                       back;
        logic                       pend;
        logic                       pend_back;
        logic [8:0]                 pend_cnt;
    } mws_chan_t;

endpackage

// [verilog/mws_table_mem.sv]
// Quarter-wave table memory: eight words of one-bit entries, registered read ports.
// Assumes one clock; bit ports are read by the sequencer, the word port by software.
`timescale 1ns/100ps
`include "mws_cfg.svh"

module mws_table_mem #(
    parameter int WORDS = `MWS_TABLE_WORDS,
    parameter int NRD   = 4
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    // Software word port
    input  wire logic                 i_wr,
    input  wire logic [2:0]           i_widx,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_rd,
    input  wire logic                 i_rd_tbl,
    input  wire logic [2:0]           i_ridx,
    input  wire logic [31:0]          i_alt,
    output logic      [31:0]          o_rdata,
    // Sequencer bit ports
    input  wire logic [NRD-1:0][7:0]  i_baddr,
    output logic      [NRD-1:0]       o_bit
);

    // Eight-bit entry addresses only reach 256 bits
    if (WORDS != 8 || NRD < 1) begin : g_check
        $error("mws_table_mem: WORDS must be 8 and NRD at least 1");
    end

    typedef struct packed {
        logic [WORDS-1:0][31:0] word;
        logic [31:0]            rdata;
        logic [NRD-1:0]         bits;
    } mws_mem_t;

    localparam logic [WORDS-1:0][31:0] RST_WORDS = {
        `MWS_RST_TABLE7, `MWS_RST_TABLE6, `MWS_RST_TABLE5, `MWS_RST_TABLE4,
        `MWS_RST_TABLE3, `MWS_RST_TABLE2, `MWS_RST_TABLE1, `MWS_RST_TABLE0
    };

    mws_mem_t mem_r;
    mws_mem_t mem_nxt;

    always_comb begin
        mem_nxt = mem_r;
        if (i_wr) begin
            mem_nxt.word[i_widx] = i_wdata;
        end
        // Read data stand for one cycle only, zero otherwise
        mem_nxt.rdata = '0;
        if (i_rd) begin
            mem_nxt.rdata = i_rd_tbl ? mem_r.word[i_ridx] : i_alt;
        end
        for (int k = 0; k < NRD; k++) begin
            mem_nxt.bits[k] = mem_r.word[i_baddr[k][7:5]][i_baddr[k][4:0]];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_r <= {RST_WORDS, 32'h00000000, {NRD{1'b0}}};
        end else begin
            mem_r <= mem_nxt;
        end
    end

    assign o_rdata = mem_r.rdata;
    assign o_bit   = mem_r.bits;

endmodule

// [verilog/mws_sequencer.sv]
// Microstep wave sequencer: shared quarter-wave table driving step/dir channels.
// Assumes one 100 MHz clock, a strobe register port and raw step/dir pins.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "mws_cfg.svh"

module mws_sequencer #(
    parameter int NUM_MOTORS = 2
) (
    // Clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_rstn,
    // Register port
    input  wire mws_pkg::mws_bus_t                   i_bus,
    output logic      [31:0]                         o_rdata,
    // Step and direction pins
    input  wire logic [NUM_MOTORS-1:0]               i_step,
    input  wire logic [NUM_MOTORS-1:0]               i_dir,
    // Coil currents and position
    output mws_pkg::mws_coil_t [NUM_MOTORS-1:0]      o_coil,
    output logic      [NUM_MOTORS-1:0][9:0]          o_position,
    // Mode outputs
    output logic      [NUM_MOTORS-1:0]               o_ext_step_mode,
    output logic      [NUM_MOTORS-1:0]               o_fullstep_allow
);

    // Control and status offsets leave room for two motors only
    if (NUM_MOTORS < 1 || NUM_MOTORS > 2) begin : g_check
        $error("mws_sequencer: NUM_MOTORS must be 1 or 2");
    end

    localparam int          NRD       = 2 * NUM_MOTORS;
    localparam logic [31:0] RST_START = `MWS_RST_START;

    typedef struct packed {
        logic [31:0]                         segsel;
        logic [31:0]                         start;
        logic [NUM_MOTORS-1:0][31:0]         ctrl;
        logic [NUM_MOTORS-1:0]               fs_allow;
        mws_pkg::mws_chan_t [NUM_MOTORS-1:0] ch;
    } mws_state_t;

    function automatic mws_state_t mws_reset_state();
        mws_state_t s;
        s        = '0;
        s.segsel = `MWS_RST_SEGSEL;
        s.start  = `MWS_RST_START;
        for (int m = 0; m < NUM_MOTORS; m++) begin
            s.ctrl[m]          = `MWS_RST_CTRL;
            s.ch[m].seq        = mws_pkg::MWS_IDLE;
            s.ch[m].coil.coil_a_current = {1'b0, RST_START[`MWS_START_A_LSB +: 8]};
            s.ch[m].coil.coil_b_current = {1'b0, RST_START[`MWS_START_B_LSB +: 8]};
        end
        return s;
    endfunction

    localparam mws_state_t ST_RST = mws_reset_state();

    // Table position of the microstep being walked
    function automatic logic [9:0] mws_pp(input mws_pkg::mws_chan_t c);
        return c.back ? 10'(c.pos - 10'h001) : c.pos;
    endfunction

    // Increment between one entry and the next
    function automatic logic signed [3:0] mws_delta(
        input logic [7:0]  idx,
        input logic        tbit,
        input logic [31:0] sel
    );
        int         seg;
        logic [1:0] code;
        if (idx < sel[`MWS_SEL_X1_LSB +: 8]) begin
            seg = 0;
        end else if (idx < sel[`MWS_SEL_X2_LSB +: 8]) begin
            seg = 1;
        end else if (idx < sel[`MWS_SEL_X3_LSB +: 8]) begin
            seg = 2;
        end else begin
            seg = 3;
        end
        code = sel[`MWS_SEL_W_LSB + 2 * seg +: 2];
        // Code is the slope plus one, so 00 gives a falling segment
        return $signed({2'b00, code}) - 4'sh1 + $signed({3'b000, tbit});
    endfunction

    // Quadrants 1 and 2 run the wave downward; walking back negates it again
    function automatic logic [8:0] mws_step_cur(
        input logic [8:0]        cur,
        input logic [1:0]        quad,
        input logic              back,
        input logic signed [3:0] d
    );
        logic              neg;
        logic signed [8:0] dx;
        neg = quad[1] ^ quad[0] ^ back;
        dx  = 9'(d);
        return neg ? 9'(cur - $unsigned(dx)) : 9'(cur + $unsigned(dx));
    endfunction

    // Width saturates at a full quarter so no code selects an unserved step
    function automatic logic [8:0] mws_width(input logic [3:0] res);
        logic [3:0] r;
        r = (res > `MWS_RES_MAX) ? `MWS_RES_MAX : res;
        return 9'h001 << r;
    endfunction

    mws_state_t          st_r;
    mws_state_t          st_nxt;
    logic [NRD-1:0][7:0] bit_addr;
    logic [NRD-1:0]      tbl_bit;
    logic                tbl_hit;
    logic                tbl_wr;
    logic [31:0]         rd_alt;

    // Register decode and read selection
    always_comb begin
        tbl_hit = (i_bus.addr < `MWS_OFS_SEGSEL) && (i_bus.addr[1:0] == 2'h0);
        tbl_wr  = i_bus.wr && tbl_hit;
        rd_alt  = '0;
        if (i_bus.addr == `MWS_OFS_SEGSEL) begin
            rd_alt = st_r.segsel;
        end
        if (i_bus.addr == `MWS_OFS_START) begin
            rd_alt = st_r.start;
        end
        for (int m = 0; m < NUM_MOTORS; m++) begin
            if (i_bus.addr == `MWS_OFS_CTRL0 + 8'(4 * m)) begin
                rd_alt = st_r.ctrl[m];
            end
            if (i_bus.addr == `MWS_OFS_STAT0 + 8'(4 * m)) begin
                rd_alt = {2'b00, st_r.ch[m].seq, st_r.ch[m].coil.coil_b_current,
                          st_r.ch[m].coil.coil_a_current, st_r.ch[m].pos};
            end
        end
    end

    // Entry addresses stay put from fetch through apply
    always_comb begin
        logic [9:0] pp;
        pp = '0;
        for (int m = 0; m < NUM_MOTORS; m++) begin
            pp                = mws_pp(st_r.ch[m]);
            bit_addr[2*m]     = pp[7:0];
            bit_addr[2*m+1]   = ~pp[7:0];
        end
    end

    mws_table_mem #(
        .WORDS   (`MWS_TABLE_WORDS),
        .NRD     (NRD)
    ) u_table (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_wr     (tbl_wr),
        .i_widx   (i_bus.addr[4:2]),
        .i_wdata  (i_bus.wdata),
        .i_rd     (i_bus.rd),
        .i_rd_tbl (tbl_hit),
        .i_ridx   (i_bus.addr[4:2]),
        .i_alt    (rd_alt),
        .o_rdata  (o_rdata),
        .i_baddr  (bit_addr),
        .o_bit    (tbl_bit)
    );

    always_comb begin
        logic [9:0] pp;
        logic [9:0] np;
        logic [1:0] qa;
        logic [1:0] qb;
        logic [7:0] ia;
        logic [7:0] ib;
        logic       ba;
        logic       bb;
        logic       act;
        logic       ext;
        logic       dedge;
        logic [8:0] width;
        pp     = '0;
        np     = '0;
        qa     = '0;
        qb     = '0;
        ia     = '0;
        ib     = '0;
        ba     = 1'b0;
        bb     = 1'b0;
        act    = 1'b0;
        ext    = 1'b0;
        dedge  = 1'b0;
        width  = '0;
        st_nxt = st_r;

        if (i_bus.wr) begin
            if (i_bus.addr == `MWS_OFS_SEGSEL) begin
                st_nxt.segsel = i_bus.wdata;
            end
            if (i_bus.addr == `MWS_OFS_START) begin
                st_nxt.start = i_bus.wdata;
            end
            for (int m = 0; m < NUM_MOTORS; m++) begin
                if (i_bus.addr == `MWS_OFS_CTRL0 + 8'(4 * m)) begin
                    st_nxt.ctrl[m] = i_bus.wdata & `MWS_CTRL_MASK;
                end
            end
        end

        for (int m = 0; m < NUM_MOTORS; m++) begin
            ext   = st_r.ctrl[m][`MWS_CTRL_EXT];
            dedge = st_r.ctrl[m][`MWS_CTRL_DEDGE];
            width = mws_width(st_r.ctrl[m][`MWS_CTRL_RES_LSB +: 4]);
            st_nxt.fs_allow[m] = st_r.ctrl[m][`MWS_CTRL_FS] & ~ext;

            // Only the second and third stages are ever compared
            st_nxt.ch[m].step_sy = {st_r.ch[m].step_sy[1:0], i_step[m]};
            st_nxt.ch[m].dir_sy  = {st_r.ch[m].dir_sy[1:0], i_dir[m]};
            act = 1'b0;
            if (st_r.ch[m].dir_sy[1] == st_r.ch[m].dir_sy[2]) begin
                st_nxt.ch[m].dir_lv = st_r.ch[m].dir_sy[2];
            end
            if (st_r.ch[m].step_sy[1] == st_r.ch[m].step_sy[2] &&
                st_r.ch[m].step_sy[2] != st_r.ch[m].step_lv) begin
                st_nxt.ch[m].step_lv = st_r.ch[m].step_sy[2];
                // Without external mode the pins move nothing
                act = ext && (st_r.ch[m].step_sy[2] || dedge);
            end

            unique case (st_r.ch[m].seq)
                mws_pkg::MWS_IDLE: begin
                    if (st_r.ch[m].pend) begin
                        st_nxt.ch[m].seq  = mws_pkg::MWS_FETCH;
                        st_nxt.ch[m].left = st_r.ch[m].pend_cnt;
                        st_nxt.ch[m].back = st_r.ch[m].pend_back;
                        st_nxt.ch[m].pend = 1'b0;
                    end
                end
                mws_pkg::MWS_FETCH: begin
                    st_nxt.ch[m].seq = mws_pkg::MWS_APPLY;
                end
                mws_pkg::MWS_APPLY: begin
                    pp = mws_pp(st_r.ch[m]);
                    qa = pp[9:8];
                    qb = 2'(qa + 2'h1);
                    ia = qa[0] ? ~pp[7:0] : pp[7:0];
                    ba = qa[0] ? tbl_bit[2*m+1] : tbl_bit[2*m];
                    ib = qb[0] ? ~pp[7:0] : pp[7:0];
                    bb = qb[0] ? tbl_bit[2*m+1] : tbl_bit[2*m];
                    np = st_r.ch[m].back ? 10'(st_r.ch[m].pos - 10'h001)
                                         : 10'(st_r.ch[m].pos + 10'h001);
                    st_nxt.ch[m].coil.coil_a_current = mws_step_cur(st_r.ch[m].coil.coil_a_current, qa,
                        st_r.ch[m].back, mws_delta(ia, ba, st_r.segsel));
                    st_nxt.ch[m].coil.coil_b_current = mws_step_cur(st_r.ch[m].coil.coil_b_current, qb,
                        st_r.ch[m].back, mws_delta(ib, bb, st_r.segsel));
                    // Absolute reload bounds drift after a table rewrite
                    if (np == 10'h000) begin
                        st_nxt.ch[m].coil.coil_a_current =
                            {1'b0, st_r.start[`MWS_START_A_LSB +: 8]};
                        st_nxt.ch[m].coil.coil_b_current =
                            {1'b0, st_r.start[`MWS_START_B_LSB +: 8]};
                    end
                    st_nxt.ch[m].pos  = np;
                    st_nxt.ch[m].left = 9'(st_r.ch[m].left - 9'h001);
                    st_nxt.ch[m].seq  = (st_r.ch[m].left == 9'h001) ? mws_pkg::MWS_IDLE
                                                                    : mws_pkg::MWS_FETCH;
                end
                default: begin
                    st_nxt.ch[m].seq = mws_pkg::MWS_IDLE;
                end
            endcase

            // One step may wait while another walks; a third overwrites it
            if (act) begin
                if (st_nxt.ch[m].seq == mws_pkg::MWS_IDLE && !st_nxt.ch[m].pend) begin
                    st_nxt.ch[m].seq  = mws_pkg::MWS_FETCH;
                    st_nxt.ch[m].left = width;
                    st_nxt.ch[m].back = st_nxt.ch[m].dir_lv;
                end else begin
                    st_nxt.ch[m].pend      = 1'b1;
                    st_nxt.ch[m].pend_cnt  = width;
                    st_nxt.ch[m].pend_back = st_nxt.ch[m].dir_lv;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        for (int m = 0; m < NUM_MOTORS; m++) begin
            o_coil[m]          = st_r.ch[m].coil;
            o_position[m]      = st_r.ch[m].pos;
            o_ext_step_mode[m] = st_r.ctrl[m][`MWS_CTRL_EXT];
        end
        o_fullstep_allow = st_r.fs_allow;
    end

endmodule

// [tb/mws_sequencer_props.sv]
// Checker for the microstep wave sequencer: timing and value relations at its ports.
// Assumes two motors and the constants header on the include path.
`timescale 1ns/100ps
`include "mws_cfg.svh"

module mws_sequencer_props #(
    parameter int NUM_MOTORS = 2
) (
    // Clock and reset
    input wire logic                               i_clk,
    input wire logic                               i_rstn,
    // Register port
    input wire mws_pkg::mws_bus_t                  i_bus,
    input wire logic [31:0]                        o_rdata,
    // Pins and outputs
    input wire logic [NUM_MOTORS-1:0]              i_step,
    input wire logic [NUM_MOTORS-1:0]              i_dir,
    input wire mws_pkg::mws_coil_t [NUM_MOTORS-1:0] o_coil,
    input wire logic [NUM_MOTORS-1:0][9:0]         o_position,
    input wire logic [NUM_MOTORS-1:0]              o_ext_step_mode,
    input wire logic [NUM_MOTORS-1:0]              o_fullstep_allow
);
    logic [31:0]       start_r;
    logic [8:0]        prev_a_r;
    logic signed [9:0] dif_a;

    // Shadow of the start values, so the reload check follows software writes
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            start_r  <= `MWS_RST_START;
            prev_a_r <= 9'h000;
        end else begin
            if (i_bus.wr && i_bus.addr == `MWS_OFS_START) begin
                start_r <= i_bus.wdata;
            end
            prev_a_r <= o_coil[0].coil_a_current;
        end
    end

    assign dif_a = $signed({o_coil[0].coil_a_current[8], o_coil[0].coil_a_current}) - $signed({prev_a_r[8], prev_a_r});

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_step_taken;
        $changed(o_position[0]);
    endsequence
    sequence s_fs_req;
        i_bus.wr && i_bus.addr == 8'h2C && i_bus.wdata[6] && !i_bus.wdata[5];
    endsequence

    property p_ext_mode;
        i_bus.wr && i_bus.addr == `MWS_OFS_CTRL0 |=> o_ext_step_mode[0] == $past(i_bus.wdata[5]);
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("ext mode does not follow control write");
    property p_fs_allow;
        s_fs_req |=> ##1 o_fullstep_allow[1];
    endproperty
    a_fs_allow: assert property (p_fs_allow) else $error("fullstep allow not raised");
    property p_fs_bar;
        o_ext_step_mode[1] && $past(o_ext_step_mode[1]) |-> !o_fullstep_allow[1];
    endproperty
    a_fs_bar: assert property (p_fs_bar) else $error("fullstep allowed in step mode");
    property p_pos_unit;
        s_step_taken |-> (10'(o_position[0] - $past(o_position[0])) == 10'h001)
                      || (10'(o_position[0] - $past(o_position[0])) == 10'h3FF);
    endproperty
    a_pos_unit: assert property (p_pos_unit) else $error("position moved by more than one");
    property p_step_gap;
        s_step_taken |=> $stable(o_position[0]);
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("microsteps closer than two cycles");
    property p_coil_small;
        s_step_taken ##0 (o_position[0] != 10'h000) |-> dif_a <= 10'sd3 && dif_a >= -10'sd3;
    endproperty
    a_coil_small: assert property (p_coil_small) else $error("coil a step out of slope range");
    property p_zero_reload;
        s_step_taken ##0 (o_position[0] == 10'h000)
            |-> o_coil[0].coil_a_current == {1'b0, start_r[7:0]} && o_coil[0].coil_b_current == {1'b0, start_r[23:16]};
    endproperty
    a_zero_reload: assert property (p_zero_reload) else $error("no reload at position zero");
    property p_coil_tied;
        $changed(o_coil[0]) |-> $changed(o_position[0]);
    endproperty
    a_coil_tied: assert property (p_coil_tied) else $error("coil changed without a microstep");
endmodule

bind mws_sequencer mws_sequencer_props #(.NUM_MOTORS(NUM_MOTORS)) u_props (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_step(i_step), .i_dir(i_dir), .o_coil(o_coil), .o_position(o_position),
    .o_ext_step_mode(o_ext_step_mode), .o_fullstep_allow(o_fullstep_allow)
);

// [tb/mws_step_src.sv]
// External motion controller model: drives one step/direction pin pair.
// Assumes the bench calls pulse(); pins are always driven, never released.
`timescale 1ns/100ps

module mws_step_src (
    // Clock
    input  wire logic i_clk,
    // Step and direction pins
    output logic      o_step,
    output logic      o_dir
);
    initial begin
        o_step = 1'b0;
        o_dir  = 1'b0;
    end

    // Short hi/lo give a prompt source, long ones a slow one
    task automatic pulse(input logic dir, input int hi, input int lo);
        @(posedge i_clk);
        o_dir <= dir;
        // Direction settles well before the edge is accepted
        repeat (4) @(posedge i_clk);
        o_step <= 1'b1;
        repeat (hi) @(posedge i_clk);
        o_step <= 1'b0;
        repeat (lo) @(posedge i_clk);
    endtask
endmodule

// [tb/tb_top.sv]
// Testbench for the microstep wave sequencer: registers, step/dir walks, wave values.
// Assumes two step sources as far side and the bound port checker.
`timescale 1ns/100ps
`include "mws_cfg.svh"

module tb_top;
    logic                     i_clk;
    logic                     i_rstn;
    mws_pkg::mws_bus_t        bus;
    logic [31:0]              rdata;
    logic [1:0]               step;
    logic [1:0]               dir;
    mws_pkg::mws_coil_t [1:0] coil;
    logic [1:0][9:0]          pos;
    logic [1:0]               ext;
    logic [1:0]               fs;
    int                       error_cnt;
    int                       n_tests;
    localparam logic [31:0] DFLT [8] = '{`MWS_RST_TABLE0, `MWS_RST_TABLE1, `MWS_RST_TABLE2,
        `MWS_RST_TABLE3, `MWS_RST_TABLE4, `MWS_RST_TABLE5, `MWS_RST_TABLE6, `MWS_RST_TABLE7};

    mws_sequencer #(.NUM_MOTORS(2)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(bus),
        .o_rdata(rdata), .i_step(step), .i_dir(dir), .o_coil(coil), .o_position(pos),
        .o_ext_step_mode(ext), .o_fullstep_allow(fs));
    mws_step_src u_src0 (.i_clk(i_clk), .o_step(step[0]), .o_dir(dir[0]));
    mws_step_src u_src1 (.i_clk(i_clk), .o_step(step[1]), .o_dir(dir[1]));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1;
        chk("read data", rdata, exp);
    endtask
    // Walks take up to 3 + 2 * 256 cycles, so the bound leaves margin
    task automatic wait_pos(input int m, input logic [9:0] exp);
        int k;
        k = 0;
        while (pos[m] !== exp && k < 800) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk("position", {22'h0, pos[m]}, {22'h0, exp});
    endtask
    task automatic coil_chk(input int m, input logic [8:0] a, input logic [8:0] b);
        chk("coil a current", {23'h0, coil[m].coil_a_current}, {23'h0, a});
        chk("coil b current", {23'h0, coil[m].coil_b_current}, {23'h0, b});
    endtask

    task automatic t_defaults();
        for (int w = 0; w < 8; w++) begin
            rd_chk(8'(w * 4), DFLT[w]);
        end
        rd_chk(`MWS_OFS_SEGSEL, 32'hFFFF8056);
        rd_chk(`MWS_OFS_START, 32'h00F70000);
        rd_chk(8'h40, 32'h00000000);
        coil_chk(0, 9'h000, 9'h0F7);
    endtask
    task automatic t_basic();
        u_src0.pulse(1'b0, 3, 3);
        repeat (10) @(posedge i_clk);
        #1;
        chk("position", {22'h0, pos[0]}, 32'h00000000);
        wr(`MWS_OFS_CTRL0, 32'h00000020);
        u_src0.pulse(1'b0, 3, 3);
        wait_pos(0, 10'h001);
        coil_chk(0, 9'h001, 9'h0F7);
        u_src0.pulse(1'b1, 3, 3);
        wait_pos(0, 10'h000);
        coil_chk(0, 9'h000, 9'h0F7);
        u_src0.pulse(1'b1, 3, 3);
        wait_pos(0, 10'h3FF);
        coil_chk(0, 9'h1FF, 9'h0F7);
        u_src0.pulse(1'b0, 3, 3);
        wait_pos(0, 10'h000);
        coil_chk(0, 9'h000, 9'h0F7);
        rd_chk(`MWS_OFS_STAT0, 32'h07B80000);
    endtask
    task automatic t_res();
        logic [9:0] exp;
        exp = 10'h000;
        // Coarse widths first, so the early switches land on half and full steps
        for (int r = 8; r >= 0; r--) begin
            wr(`MWS_OFS_CTRL0, 32'h00000020 | 32'(r));
            u_src0.pulse(1'b0, 3, 3);
            exp = exp + 10'(1 << r);
            wait_pos(0, exp);
        end
        wr(`MWS_OFS_CTRL0, 32'h00000030);
        u_src0.pulse(1'b0, 8, 8);
        wait_pos(0, exp + 10'h002);
    endtask
    task automatic t_motor1();
        wr(8'h2C, 32'h00000040);
        repeat (2) @(posedge i_clk);
        #1;
        chk("fullstep allow", {31'h0, fs[1]}, 32'h00000001);
        wr(8'h2C, 32'h00000060);
        repeat (2) @(posedge i_clk);
        #1;
        chk("fullstep allow", {31'h0, fs[1]}, 32'h00000000);
        chk("ext step mode", {31'h0, ext[1]}, 32'h00000001);
        u_src1.pulse(1'b0, 3, 3);
        wait_pos(1, 10'h001);
        coil_chk(1, 9'h001, 9'h0F7);
    endtask
    task automatic t_custom();
        logic [8:0] ca [4];
        ca = '{9'h004, 9'h005, 9'h006, 9'h009};
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        #1;
        coil_chk(0, 9'h000, 9'h0F7);
        wr(`MWS_OFS_CTRL0, 32'h00000020);
        // Small custom wave keeps the swing far inside the allowed range
        wr(`MWS_OFS_SEGSEL, 32'h030201E4);
        wr(`MWS_OFS_TABLE0, 32'h0000000A);
        wr(`MWS_OFS_START, 32'h00F00005);
        rd_chk(`MWS_OFS_TABLE0, 32'h0000000A);
        u_src0.pulse(1'b0, 3, 3);
        wait_pos(0, 10'h001);
        u_src0.pulse(1'b1, 3, 3);
        wait_pos(0, 10'h000);
        coil_chk(0, 9'h005, 9'h0F0);
        for (int k = 0; k < 4; k++) begin
            u_src0.pulse(1'b0, 3, 3);
            wait_pos(0, 10'(k + 1));
            chk("coil a current", {23'h0, coil[0].coil_a_current}, {23'h0, ca[k]});
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        i_rstn = 1'b0;
        bus = '0;
        error_cnt = 0;
        n_tests = 0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        t_defaults();
        t_basic();
        t_res();
        t_motor1();
        t_custom();
        close_out();
    end

    // Whole run needs under two thousand cycles; this cuts a hang short
    initial begin
        repeat (30000) @(posedge i_clk);
        error_cnt++;
        close_out();
    end
endmodule
